// >>> logic/pdw_pkg.sv
// types shared by the process data watchdog files
package pdw_pkg;

  // ****************************************
  // types
  // ****************************************
  typedef logic [15:0] pdw_word_t;

  typedef enum logic [1:0] {
    PDW_SEL_NONE,
    PDW_SEL_MULT,
    PDW_SEL_LOCAL,
    PDW_SEL_SYNC
  } pdw_sel_e;

  typedef enum logic [1:0] {
    PDW_WD_IDLE,
    PDW_WD_ARMED,
    PDW_WD_EXPIRED
  } pdw_wd_state_e;

endpackage

// >>> logic/pdw_regs.svh
// register offsets, reset values and timing counts of the process data watchdog pair
`ifndef PDW_REGS_SVH
`define PDW_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define PDW_ADDR_W 12
`define PDW_ADDR_MULT 12'h400
`define PDW_ADDR_LOCAL 12'h410
`define PDW_ADDR_SYNC 12'h420

// ****************************************
// reset values
// ****************************************
`define PDW_RST_MULT 16'h09c2
`define PDW_RST_LOCAL 16'h03e8
`define PDW_RST_SYNC 16'h03e8
`define PDW_DEFAULT_TIMEOUT_MS 100

// ****************************************
// timing
// ****************************************
`define PDW_CLK_PERIOD_NS 4
`define PDW_BASE_PERIOD_NS 40
`define PDW_BASE_CYCLES (`PDW_BASE_PERIOD_NS / `PDW_CLK_PERIOD_NS)
`define PDW_TICK_EXTRA 2

`endif

// >>> logic/pdw_tick_gen.sv
// shared watchdog tick generator: 40 ns base ticks, then multiplier plus two of them per tick
`include "pdw_regs.svh"

module pdw_tick_gen #(
  parameter int BASE_CYCLES = `PDW_BASE_CYCLES,
  parameter int MULT_W = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [MULT_W-1:0] multiplier,
  output logic wdTick
);

  localparam int BASE_W = $clog2(BASE_CYCLES + 1);
  localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(BASE_CYCLES - 1);

  logic [BASE_W-1:0] baseCnt_ff;
  logic [MULT_W:0] tickCnt_ff;
  logic wdTick_ff;
  wire logic baseTick;
  wire logic [MULT_W:0] tickLast;
  wire logic tickWrap;

  // ****************************************
  // dividers
  // ****************************************
  assign baseTick = (baseCnt_ff == BASE_LAST);
  // compare against multiplier+1 so a multiplier change mid-tick still ends the tick
  assign tickLast = {1'b0, multiplier} + (MULT_W+1)'(`PDW_TICK_EXTRA - 1);
  assign tickWrap = baseTick && (tickCnt_ff >= tickLast);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      baseCnt_ff <= '0;
      tickCnt_ff <= '0;
      wdTick_ff <= 1'b0;
    end else if (ce) begin
      baseCnt_ff <= baseTick ? '0 : baseCnt_ff + 1'b1;
      if (baseTick) begin
        tickCnt_ff <= tickWrap ? '0 : tickCnt_ff + 1'b1;
      end
      wdTick_ff <= tickWrap;
    end
  end

  assign wdTick = wdTick_ff;

endmodule

// >>> logic/pdw_watchdog.sv
// sync channel and local process port watchdogs with safe output forcing
//
// Notes on behaviour
// - on sync channel timeout, outputs are forced to the preset safe value
// - two independent watchdogs, both default to a 100 ms timeout
// - one multiplier register at 400h sets the tick for both watchdogs
// - timers at 410h (local port) and 420h (sync channel) scale the shared tick
// - each successful process data exchange restarts the sync channel counter
// - sync channel watchdog fires after its time passes with no exchange, if enabled
// - a sync channel trigger does not alter the device state machine
// - a fired sync channel watchdog is cleared by a process data access or by a zero sync channel timer
// - local port watchdog fires after its enabled time passes with no local access
// - tick is multiplier plus two periods of 40 ns; timeout is tick times timer
// - multiplier resets to 2498 and sync channel timer to 1000
// - a timer value of zero disables that watchdog, outputs are not forced
// - counters are wide enough for about 170 seconds of timeout
// - by default outputs stay safe in safe running state unless monitoring disabled
`include "pdw_regs.svh"

module pdw_watchdog #(
  parameter int DATA_W = 16,
  parameter int OUT_W = 8,
  parameter int BASE_CYCLES = `PDW_BASE_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [`PDW_ADDR_W-1:0] regAddr,
  input wire logic [1:0] regWrBe,
  input wire logic [DATA_W-1:0] regWrData,
  output logic [DATA_W-1:0] regRdData,
  output logic regRdValid,
  input wire logic syncExchangeOk,
  input wire logic localPortAccess,
  input wire logic stateIsRun,
  input wire logic stateIsSafeRun,
  input wire logic [OUT_W-1:0] appOut,
  input wire logic [OUT_W-1:0] safePreset,
  output logic [OUT_W-1:0] procOut,
  output logic outputsSafe,
  output logic syncExpired,
  output logic localExpired,
  output logic syncExpireEvt,
  output logic localExpireEvt
);

  // ****************************************
  // register storage
  // ****************************************
  pdw_pkg::pdw_word_t mult_ff;
  pdw_pkg::pdw_word_t localTime_ff;
  pdw_pkg::pdw_word_t syncTime_ff;
  logic [DATA_W-1:0] regRdData_ff;
  logic regRdValid_ff;
  logic syncExpired_ff;
  logic localExpired_ff;
  logic syncExpireEvt_ff;
  logic localExpireEvt_ff;
  logic outputsSafe_ff;
  logic [OUT_W-1:0] procOut_ff;

  // ****************************************
  // address decode
  // ****************************************
  pdw_pkg::pdw_sel_e regSel;
  wire logic hitMult;
  wire logic hitLocal;
  wire logic hitSync;
  wire logic [DATA_W-1:0] wrMask;
  wire logic [DATA_W-1:0] nxt_mult;
  wire logic [DATA_W-1:0] nxt_localTime;
  wire logic [DATA_W-1:0] nxt_syncTime;
  wire logic [DATA_W-1:0] rdMux;

  assign hitMult = (regAddr == `PDW_ADDR_MULT);
  assign hitLocal = (regAddr == `PDW_ADDR_LOCAL);
  assign hitSync = (regAddr == `PDW_ADDR_SYNC);
  assign regSel = hitMult ? pdw_pkg::PDW_SEL_MULT :
                  hitLocal ? pdw_pkg::PDW_SEL_LOCAL :
                  hitSync ? pdw_pkg::PDW_SEL_SYNC : pdw_pkg::PDW_SEL_NONE;

  // byte lanes let the master update one half of a timer on its own
  assign wrMask = {{(DATA_W/2){regWrBe[1]}}, {(DATA_W/2){regWrBe[0]}}};
  assign nxt_mult = (mult_ff & ~wrMask) | (regWrData & wrMask);
  assign nxt_localTime = (localTime_ff & ~wrMask) | (regWrData & wrMask);
  assign nxt_syncTime = (syncTime_ff & ~wrMask) | (regWrData & wrMask);

  assign rdMux = (regSel == pdw_pkg::PDW_SEL_MULT) ? mult_ff :
                 (regSel == pdw_pkg::PDW_SEL_LOCAL) ? localTime_ff :
                 (regSel == pdw_pkg::PDW_SEL_SYNC) ? syncTime_ff : '0;

  // ****************************************
  // register writes and reads
  // ****************************************
  wire logic wrMult;
  wire logic wrLocal;
  wire logic wrSync;
  wire logic rdTake;

  assign wrMult = ce && regWrEn && (regSel == pdw_pkg::PDW_SEL_MULT);
  assign wrLocal = ce && regWrEn && (regSel == pdw_pkg::PDW_SEL_LOCAL);
  assign wrSync = ce && regWrEn && (regSel == pdw_pkg::PDW_SEL_SYNC);
  assign rdTake = ce && regRdEn;

  // no write means no change: values survive a startup without download
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mult_ff <= `PDW_RST_MULT;
    end else if (wrMult) begin
      mult_ff <= nxt_mult;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      localTime_ff <= `PDW_RST_LOCAL;
    end else if (wrLocal) begin
      localTime_ff <= nxt_localTime;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      syncTime_ff <= `PDW_RST_SYNC;
    end else if (wrSync) begin
      syncTime_ff <= nxt_syncTime;
    end
  end

  // the valid pulse follows every taken strobe; the data holds until the next read
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      regRdValid_ff <= 1'b0;
    end else if (ce) begin
      regRdValid_ff <= regRdEn;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      regRdData_ff <= '0;
    end else if (rdTake) begin
      regRdData_ff <= rdMux;
    end
  end

  // ****************************************
  // shared tick
  // ****************************************
  wire logic wdTick;

  // the 17-bit tick counter and 16-bit timers together span about 171 s
  pdw_tick_gen #(
    .BASE_CYCLES(BASE_CYCLES),
    .MULT_W(DATA_W)
  ) u_tick (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .multiplier(mult_ff),
    .wdTick(wdTick)
  );

  // ****************************************
  // the two watchdogs
  // ****************************************
  wire logic syncTimeout;
  wire logic localTimeout;
  wire logic syncEnabled;
  wire logic localEnabled;

  assign syncEnabled = (syncTime_ff != '0);
  assign localEnabled = (localTime_ff != '0);

  // a kick can land anywhere inside a tick, so a timeout runs short by up to one tick
  pdw_wd_counter #(
    .TIME_W(DATA_W)
  ) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .kick(syncExchangeOk),
    .wdTick(wdTick),
    .timeValue(syncTime_ff),
    .timeout(syncTimeout),
    .armed()
  );

  pdw_wd_counter #(
    .TIME_W(DATA_W)
  ) u_local (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .kick(localPortAccess),
    .wdTick(wdTick),
    .timeValue(localTime_ff),
    .timeout(localTimeout),
    .armed()
  );

  // ****************************************
  // expired flags
  // ****************************************
  wire logic nxt_syncExpired;
  wire logic nxt_localExpired;

  // resumed traffic clears; a kick wins over a registered timeout arriving in the same cycle
  assign nxt_syncExpired = !syncEnabled ? 1'b0 :
                           syncExchangeOk ? 1'b0 :
                           (syncTimeout | syncExpired_ff);
  assign nxt_localExpired = !localEnabled ? 1'b0 :
                            localPortAccess ? 1'b0 :
                            (localTimeout | localExpired_ff);

  wire logic nxt_syncExpireEvt;
  wire logic nxt_localExpireEvt;

  // the pulse marks the cycle in which the flag rises, for event counting outside
  assign nxt_syncExpireEvt = syncTimeout && syncEnabled && !syncExchangeOk;
  assign nxt_localExpireEvt = localTimeout && localEnabled && !localPortAccess;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      syncExpired_ff <= 1'b0;
    end else if (ce) begin
      syncExpired_ff <= nxt_syncExpired;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      localExpired_ff <= 1'b0;
    end else if (ce) begin
      localExpired_ff <= nxt_localExpired;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      syncExpireEvt_ff <= 1'b0;
    end else if (ce) begin
      syncExpireEvt_ff <= nxt_syncExpireEvt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      localExpireEvt_ff <= 1'b0;
    end else if (ce) begin
      localExpireEvt_ff <= nxt_localExpireEvt;
    end
  end

  // ****************************************
  // output forcing
  // ****************************************
  wire logic monitorOn;
  wire logic holdSafe;
  wire logic nxt_outputsSafe;
  wire logic [OUT_W-1:0] nxt_procOut;

  // device state is only read here, never driven: a trigger leaves run state alone
  assign monitorOn = syncEnabled;
  assign holdSafe = stateIsSafeRun && monitorOn;
  assign nxt_outputsSafe = (syncExpired_ff && monitorOn) || localExpired_ff || holdSafe ||
                           !(stateIsRun || stateIsSafeRun);
  assign nxt_procOut = nxt_outputsSafe ? safePreset : appOut;

  // reset starts safe so nothing reaches the pins before the first enabled cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      outputsSafe_ff <= 1'b1;
    end else if (ce) begin
      outputsSafe_ff <= nxt_outputsSafe;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      procOut_ff <= '0;
    end else if (ce) begin
      procOut_ff <= nxt_procOut;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign regRdData = regRdData_ff;
  assign regRdValid = regRdValid_ff;
  assign syncExpired = syncExpired_ff;
  assign localExpired = localExpired_ff;
  assign syncExpireEvt = syncExpireEvt_ff;
  assign localExpireEvt = localExpireEvt_ff;
  assign outputsSafe = outputsSafe_ff;
  assign procOut = procOut_ff;

endmodule

// >>> logic/pdw_wd_counter.sv
// one watchdog down counter, restarted by a kick and stopped on timeout
module pdw_wd_counter #(
  parameter int TIME_W = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic kick,
  input wire logic wdTick,
  input wire logic [TIME_W-1:0] timeValue,
  output logic timeout,
  output logic armed
);

  pdw_pkg::pdw_wd_state_e state_ff;
  pdw_pkg::pdw_wd_state_e nxt_state;
  logic [TIME_W-1:0] cnt_ff;
  logic [TIME_W-1:0] nxt_cnt;
  logic timeout_ff;
  wire logic enabled;
  wire logic lastTick;

  // ****************************************
  // counter
  // ****************************************
  assign enabled = (timeValue != '0);
  assign lastTick = wdTick && (cnt_ff <= TIME_W'(1));

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      pdw_pkg::PDW_WD_IDLE: begin
        if (kick && enabled) begin
          nxt_state = pdw_pkg::PDW_WD_ARMED;
          nxt_cnt = timeValue;
        end
      end
      pdw_pkg::PDW_WD_ARMED: begin
        if (!enabled) begin
          nxt_state = pdw_pkg::PDW_WD_IDLE;
        end else if (kick) begin
          nxt_cnt = timeValue;
        end else if (lastTick) begin
          nxt_state = pdw_pkg::PDW_WD_EXPIRED;
          nxt_cnt = '0;
        end else if (wdTick) begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      pdw_pkg::PDW_WD_EXPIRED: begin
        if (!enabled) begin
          nxt_state = pdw_pkg::PDW_WD_IDLE;
        end else if (kick) begin
          nxt_state = pdw_pkg::PDW_WD_ARMED;
          nxt_cnt = timeValue;
        end
      end
      default: begin
        nxt_state = pdw_pkg::PDW_WD_IDLE;
        nxt_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_ff <= pdw_pkg::PDW_WD_IDLE;
      cnt_ff <= '0;
      timeout_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      timeout_ff <= (state_ff == pdw_pkg::PDW_WD_ARMED) && enabled && !kick && lastTick;
    end
  end

  assign timeout = timeout_ff;
  assign armed = (state_ff == pdw_pkg::PDW_WD_ARMED);

endmodule

// >>> verification/pdw_monitor.sv
// port checker of the process data watchdog pair
module pdw_monitor #(
  parameter int OUT_W = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic regRdEn,
  input wire logic regWrEn,
  input wire logic regRdValid,
  input wire logic syncExchangeOk,
  input wire logic localPortAccess,
  input wire logic stateIsRun,
  input wire logic stateIsSafeRun,
  input wire logic [OUT_W-1:0] appOut,
  input wire logic [OUT_W-1:0] safePreset,
  input wire logic [OUT_W-1:0] procOut,
  input wire logic outputsSafe,
  input wire logic syncExpired,
  input wire logic localExpired,
  input wire logic syncExpireEvt,
  input wire logic localExpireEvt
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  read_answer_a: assert property ($past(rstn) && $past(ce) |-> regRdValid == $past(regRdEn))
    else $error("read answer not one cycle after strobe");
  sync_evt_a: assert property (syncExpireEvt && $past(ce) |-> syncExpired && !$past(syncExpired))
    else $error("sync expiry pulse without fresh flag");
  evt_single_a: assert property (localExpireEvt && ce |=> !localExpireEvt)
    else $error("local expiry pulse longer than one cycle");
  sync_sticky_a: assert property (syncExpired && !syncExchangeOk && !regWrEn && !$past(regWrEn) |=> syncExpired)
    else $error("sync flag dropped without traffic");
  sync_kick_a: assert property (syncExchangeOk && ce |=> !syncExpired)
    else $error("sync flag stays after exchange");
  local_kick_a: assert property (localPortAccess && ce |=> !localExpired)
    else $error("local flag stays after access");
  sync_force_a: assert property (syncExpireEvt && ce && !$past(regWrEn) |=> outputsSafe)
    else $error("outputs not forced after sync expiry");
  local_force_a: assert property (localExpired && ce |=> outputsSafe)
    else $error("outputs not forced after local expiry");
  no_run_a: assert property (!(stateIsRun || stateIsSafeRun) && ce |=> outputsSafe)
    else $error("outputs not safe outside running states");
  out_select_a: assert property ($past(rstn) && $past(ce) |->
    procOut == (outputsSafe ? $past(safePreset) : $past(appOut)))
    else $error("output value does not follow safe selection");
  cover property (syncExpireEvt);
  cover property (localExpireEvt);
  cover property (regRdValid);
endmodule

bind pdw_watchdog pdw_monitor #(.OUT_W(OUT_W)) u_mon (.mclk, .rstn, .ce, .regRdEn, .regWrEn, .regRdValid,
  .syncExchangeOk, .localPortAccess, .stateIsRun, .stateIsSafeRun, .appOut, .safePreset, .procOut,
  .outputsSafe, .syncExpired, .localExpired, .syncExpireEvt, .localExpireEvt);

// >>> verification/pdw_traffic_model.sv
// fieldbus master and local processor traffic: one-cycle kicks every GAP+1 cycles while enabled
module pdw_traffic_model #(
  parameter int GAP = 3
) (
  input wire logic mclk,
  input wire logic syncOn,
  input wire logic localOn,
  output logic syncExchangeOk,
  output logic localPortAccess
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt_ff = 0;
  initial syncExchangeOk = 1'b0;
  initial localPortAccess = 1'b0;
  always @(posedge mclk) begin
    cnt_ff <= (cnt_ff >= GAP) ? 0 : cnt_ff + 1;
    syncExchangeOk <= syncOn && (cnt_ff == GAP);
    localPortAccess <= localOn && (cnt_ff == GAP);
  end
endmodule

// >>> verification/tb_process_data_watchdog.sv
// self-checking testbench of the process data watchdog pair
`include "pdw_regs.svh"

module tb_process_data_watchdog;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // signals
  // ****************************************
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [1:0] regWrBe = 2'h3;
  logic [15:0] regWrData = 16'h0000;
  logic stateIsRun = 1'b1;
  logic stateIsSafeRun = 1'b0;
  logic [7:0] appOut = 8'h5a;
  logic [7:0] safePreset = 8'hc3;
  logic syncOn = 1'b0;
  logic localOn = 1'b0;
  logic ce = 1'b1;
  logic syncExchangeOk, localPortAccess, regRdValid, outputsSafe, syncExpired, localExpired;
  logic syncExpireEvt, localExpireEvt;
  logic [15:0] regRdData;
  logic [7:0] procOut;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  always #2 mclk = ~mclk;

  // base period shortened to one cycle so a tick is multiplier plus two cycles
  pdw_watchdog #(.BASE_CYCLES(1)) u_dut (.mclk, .rstn, .ce, .regWrEn, .regRdEn, .regAddr, .regWrBe,
    .regWrData, .regRdData, .regRdValid, .syncExchangeOk, .localPortAccess, .stateIsRun, .stateIsSafeRun,
    .appOut, .safePreset, .procOut, .outputsSafe, .syncExpired, .localExpired, .syncExpireEvt,
    .localExpireEvt);
  pdw_traffic_model u_traffic (.mclk, .syncOn, .localOn, .syncExchangeOk, .localPortAccess);

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge mclk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    regWrBe <= be;
    @(posedge mclk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge mclk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRdEn <= 1'b0;
    #1;
    chk("read valid", {15'h0000, regRdValid}, 16'h0001);
    chk("read data", regRdData, e);
  endtask

  // keep traffic alive past the timeout, stop it, then time the expiry; it may come up to one tick plus one kick gap early
  task automatic expire(input logic [11:0] a, input int m, input int t, input bit loc);
    int n;
    n = 0;
    wr(`PDW_ADDR_MULT, m[15:0], 2'h3);
    wr(a, t[15:0], 2'h3);
    syncOn <= 1'b1;
    localOn <= 1'b1;
    repeat (t * (m + 2) + 20) @(posedge mclk);
    chk("alive flag", {15'h0000, loc ? localExpired : syncExpired}, 16'h0000);
    syncOn <= 1'b0;
    localOn <= 1'b0;
    while ((loc ? localExpired : syncExpired) !== 1'b1 && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("expiry delay", {15'h0000, n >= (t - 1) * (m + 2) - 4 && n <= t * (m + 2) + 3}, 16'h0001);
    chk("expiry pulse", {15'h0000, loc ? localExpireEvt : syncExpireEvt}, 16'h0001);
    repeat (30) @(posedge mclk);
    chk("sticky flag", {15'h0000, loc ? localExpired : syncExpired}, 16'h0001);
    chk("pulse gone", {15'h0000, loc ? localExpireEvt : syncExpireEvt}, 16'h0000);
    chk("safe out", {8'h00, procOut}, {8'h00, safePreset});
    syncOn <= 1'b1;
    localOn <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("resumed flag", {15'h0000, loc ? localExpired : syncExpired}, 16'h0000);
    chk("resumed out", {8'h00, procOut}, {8'h00, appOut});
  endtask

  task automatic wrap_up();
    $display("errors %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // timeout
  // ****************************************
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd(`PDW_ADDR_MULT, 16'h09c2);
    rd(`PDW_ADDR_SYNC, 16'h03e8);
    rd(`PDW_ADDR_LOCAL, 16'h03e8);
    chk("idle out", {8'h00, procOut}, 16'h005a);
    wr(`PDW_ADDR_MULT, 16'hffff, 2'h1);
    rd(`PDW_ADDR_MULT, 16'h09ff);
    wr(`PDW_ADDR_LOCAL, 16'hffff, 2'h3);
    rd(`PDW_ADDR_LOCAL, 16'hffff);
    wr(12'h430, 16'hffff, 2'h3);
    rd(12'h430, 16'h0000);
    wr(`PDW_ADDR_LOCAL, 16'h0000, 2'h3);
    expire(`PDW_ADDR_SYNC, 0, 20, 1'b0);
    expire(`PDW_ADDR_SYNC, 3, 20, 1'b0);
    wr(`PDW_ADDR_SYNC, 16'h0000, 2'h3);
    expire(`PDW_ADDR_LOCAL, 0, 10, 1'b1);
    chk("sync off flag", {15'h0000, syncExpired}, 16'h0000);
    wr(`PDW_ADDR_LOCAL, 16'h0000, 2'h3);
    syncOn <= 1'b0;
    localOn <= 1'b0;
    repeat (200) @(posedge mclk);
    chk("both off", {15'h0000, outputsSafe}, 16'h0000);
    wr(`PDW_ADDR_SYNC, 16'h0005, 2'h3);
    stateIsRun <= 1'b0;
    stateIsSafeRun <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("safe running", {15'h0000, outputsSafe}, 16'h0001);
    wr(`PDW_ADDR_SYNC, 16'h0000, 2'h3);
    repeat (3) @(posedge mclk);
    chk("monitor off", {15'h0000, outputsSafe}, 16'h0000);
    stateIsSafeRun <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("not running", {15'h0000, outputsSafe}, 16'h0001);
    // a write while the clock enable is low must leave the multiplier at its last value
    ce <= 1'b0;
    wr(`PDW_ADDR_MULT, 16'h0003, 2'h3);
    ce <= 1'b1;
    rd(`PDW_ADDR_MULT, 16'h0000);
    wrap_up();
  end
endmodule
